// ==== common/wdt_pkg.sv ====
// watchdog package: register addresses, field positions, reset values, timing constants
// assumes a 250 MHz system clock (ref_clk)
package wdt_pkg;
	// ----------------------------------------------------------------
	// register addresses on the special-function bus
	// ----------------------------------------------------------------
	localparam logic [7:0] watchdog_control_addr = 8'hc1;
	localparam logic [7:0] power_control_addr = 8'h87;
	// ----------------------------------------------------------------
	// watchdog_control fields
	// ----------------------------------------------------------------
	localparam int flag_pos = 7;
	localparam int enable_pos = 5;
	localparam int restart_pos = 4;
	localparam int idle_run_pos = 3;
	localparam int ps_lsb = 0;
	localparam int ps_width = 3;
	// power_control_register field
	localparam int power_on_flag_pos = 4;
	localparam logic [7:0] control_reset_value = 8'h00;
	// ----------------------------------------------------------------
	// counter sizes and timing
	// ----------------------------------------------------------------
	localparam int base_divide = 12;
	localparam int prescale_width = 8;
	localparam int counter_width = 15;
	localparam int clock_mhz = 250;
	localparam int por_release_clocks = 32768;
	localparam int power_up_delay_ms = 200;
	localparam int power_up_delay_clocks = power_up_delay_ms * 1000 * clock_mhz;
	localparam int por_count_width = 26;
endpackage : wdt_pkg

// ==== common/wdt_tick_if.sv ====
// interface between the watchdog top and its pre-scaler stage
// assumes both sides share ref_clk
`timescale 1ns/1ps
interface wdt_tick_if;
	logic run;
	logic restart;
	logic [2:0] select;
	logic tick;
	modport ctrl (output run, output restart, output select, input tick);
	modport stage (input run, input restart, input select, output tick);
endinterface : wdt_tick_if

// ==== rtl/wdt_prescaler.sv ====
// divide-by-12 stage and selectable 8-bit pre-scaler of the watchdog
// emits one-cycle tick per (12 * 2^(sel+1)) running clocks
`timescale 1ns/1ps
module wdt_prescaler (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// control side
	wdt_tick_if.stage tif
);
	logic [3:0] div_q, div_d;
	logic [wdt_pkg::prescale_width-1:0] pre_q, pre_d;
	logic tick_q, tick_d;
	logic [wdt_pkg::prescale_width-1:0] limit;

	always_comb begin
		limit = 8'(({1'b0, 8'h01} << (9'(tif.select) + 9'h001)) - 9'h001);
		div_d = div_q;
		pre_d = pre_q;
		tick_d = 1'b0;
		if (tif.restart) begin
			div_d = 4'h0;
			pre_d = '0;
		end else if (tif.run) begin
			if (div_q == 4'(wdt_pkg::base_divide - 1)) begin
				div_d = 4'h0;
				if (pre_q >= limit) begin
					pre_d = '0;
					tick_d = 1'b1;
				end else begin
					pre_d = pre_q + 8'h01;
				end
			end else begin
				div_d = div_q + 4'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_q <= 4'h0;
			pre_q <= '0;
			tick_q <= 1'b0;
		end else begin
			div_q <= div_d;
			pre_q <= pre_d;
			tick_q <= tick_d;
		end
	end

	assign tif.tick = tick_q;
endmodule : wdt_prescaler

// ==== rtl/wdt_top.sv ====
// watchdog with power-on reset release and reset-cause flags
// assumes the cpu's special-function bus: one-cycle write strobe, combinational address for reads
`timescale 1ns/1ps
module wdt_top #(
	parameter int power_up_delay_clocks = wdt_pkg::power_up_delay_clocks,
	parameter int por_release_clocks = wdt_pkg::por_release_clocks,
	parameter int counter_width = wdt_pkg::counter_width
) (
	// clock and power-on detector
	input wire logic ref_clk,
	input wire logic rst,
	// configuration option: extended power-up delay
	input wire logic power_up_delay_en,
	// cpu state
	input wire logic cpu_idle,
	// special-function bus
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// reset outputs
	output logic system_reset,
	output logic watchdog_reset_pulse
);
	// ----------------------------------------------------------------
	// power-on release
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		por_hold = 2'b00,
		por_extend = 2'b01,
		por_run = 2'b10
	} por_state_type;

	por_state_type por_q, por_d;
	logic [wdt_pkg::por_count_width-1:0] por_cnt_q, por_cnt_d;
	logic sys_rst_q, sys_rst_d;
	logic wdt_rst_q, wdt_rst_d;

	// ----------------------------------------------------------------
	// registers and counter
	// ----------------------------------------------------------------
	logic flag_q, flag_d;
	logic enable_q, enable_d;
	logic idle_run_q, idle_run_d;
	logic [2:0] ps_q, ps_d;
	logic power_on_flag_q, power_on_flag_d;
	logic restart_q, restart_d;
	logic [counter_width-1:0] cnt_q, cnt_d;
	logic [7:0] rdata_q, rdata_d;
	logic overflow;
	logic wr_ctrl, wr_power_control_register;

	wdt_tick_if tif ();

	wdt_prescaler u_prescaler (
		.ref_clk(ref_clk),
		.rst(rst),
		.tif(tif)
	);

	assign tif.run = enable_q && !sys_rst_q && (!cpu_idle || idle_run_q);
	assign tif.restart = restart_q || sys_rst_q;
	assign tif.select = ps_q;

	always_comb begin
		wr_ctrl = 1'b0;
		wr_power_control_register = 1'b0;
		if (sfr_wr && !sys_rst_q && sfr_addr == wdt_pkg::watchdog_control_addr) begin
			wr_ctrl = 1'b1;
		end else if (sfr_wr && !sys_rst_q && sfr_addr == wdt_pkg::power_control_addr) begin
			wr_power_control_register = 1'b1;
		end
	end

	// overflow after 32768 pre-scaled ticks
	assign overflow = tif.tick && (cnt_q == {counter_width{1'b1}});

	always_comb begin
		por_d = por_q;
		por_cnt_d = por_cnt_q;
		sys_rst_d = sys_rst_q;
		wdt_rst_d = 1'b0;
		case (por_q)
			por_hold: begin
				if (por_cnt_q >= 26'(por_release_clocks - 1)) begin
					por_cnt_d = '0;
					if (power_up_delay_en) begin
						por_d = por_extend;
					end else begin
						por_d = por_run;
						sys_rst_d = 1'b0;
					end
				end else begin
					por_cnt_d = por_cnt_q + 26'h0000001;
				end
			end
			por_extend: begin
				if (por_cnt_q >= 26'(power_up_delay_clocks - 1)) begin
					por_cnt_d = '0;
					por_d = por_run;
					sys_rst_d = 1'b0;
				end else begin
					por_cnt_d = por_cnt_q + 26'h0000001;
				end
			end
			default: begin
				sys_rst_d = 1'b0;
				if (overflow) begin
					wdt_rst_d = 1'b1;
				end
			end
		endcase
	end

	always_comb begin
		enable_d = enable_q;
		idle_run_d = idle_run_q;
		ps_d = ps_q;
		restart_d = 1'b0;
		flag_d = flag_q;
		power_on_flag_d = power_on_flag_q;
		cnt_d = cnt_q;
		if (wr_ctrl) begin
			enable_d = sfr_wdata[wdt_pkg::enable_pos];
			idle_run_d = sfr_wdata[wdt_pkg::idle_run_pos];
			ps_d = sfr_wdata[wdt_pkg::ps_lsb +: wdt_pkg::ps_width];
			restart_d = sfr_wdata[wdt_pkg::restart_pos];
			if (!sfr_wdata[wdt_pkg::flag_pos]) begin
				flag_d = 1'b0;
			end
		end
		if (wr_power_control_register && !sfr_wdata[wdt_pkg::power_on_flag_pos]) begin
			power_on_flag_d = 1'b0;
		end
		if (restart_q) begin
			cnt_d = '0;
		end else if (tif.tick) begin
			cnt_d = cnt_q + counter_width'(1);
		end
		if (wdt_rst_q) begin
			// watchdog reset clears control but keeps its own flag
			enable_d = 1'b0;
			idle_run_d = 1'b0;
			ps_d = 3'h0;
			restart_d = 1'b0;
			cnt_d = '0;
			flag_d = 1'b1;
		end
		if (overflow) begin
			flag_d = 1'b1;
		end
		rdata_d = 8'h00;
		if (sfr_addr == wdt_pkg::watchdog_control_addr) begin
			rdata_d[wdt_pkg::flag_pos] = flag_q;
			rdata_d[wdt_pkg::enable_pos] = enable_q;
			rdata_d[wdt_pkg::restart_pos] = restart_q;
			rdata_d[wdt_pkg::idle_run_pos] = idle_run_q;
			rdata_d[wdt_pkg::ps_lsb +: wdt_pkg::ps_width] = ps_q;
		end else if (sfr_addr == wdt_pkg::power_control_addr) begin
			rdata_d[wdt_pkg::power_on_flag_pos] = power_on_flag_q;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			por_q <= por_hold;
			por_cnt_q <= '0;
			sys_rst_q <= 1'b1;
			wdt_rst_q <= 1'b0;
			flag_q <= 1'b0;
			enable_q <= 1'b0;
			idle_run_q <= 1'b0;
			ps_q <= 3'h0;
			power_on_flag_q <= 1'b1;
			restart_q <= 1'b0;
			cnt_q <= '0;
			rdata_q <= wdt_pkg::control_reset_value;
		end else begin
			por_q <= por_d;
			por_cnt_q <= por_cnt_d;
			sys_rst_q <= sys_rst_d;
			wdt_rst_q <= wdt_rst_d;
			flag_q <= flag_d;
			enable_q <= enable_d;
			idle_run_q <= idle_run_d;
			ps_q <= ps_d;
			power_on_flag_q <= power_on_flag_d;
			restart_q <= restart_d;
			cnt_q <= cnt_d;
			rdata_q <= rdata_d;
		end
	end

	assign sfr_rdata = rdata_q;
	assign system_reset = sys_rst_q;
	assign watchdog_reset_pulse = wdt_rst_q;
endmodule : wdt_top

// ==== sim/wdt_top_monitor.sv ====
// checker: port relations of the watchdog top
// assumes one ref_clk domain and rst asynchronous active high
`timescale 1ns/1ps
module wdt_top_monitor #(
	parameter int power_up_delay_clocks = wdt_pkg::power_up_delay_clocks,
	parameter int por_release_clocks = wdt_pkg::por_release_clocks
) (
	// watched ports
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic power_up_delay_en,
	input wire logic cpu_idle,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic system_reset,
	input wire logic watchdog_reset_pulse
);
	// ----------------------------------------------------------------
	// helper logic
	// ----------------------------------------------------------------
	logic [31:0] por_cnt_q;
	logic [31:0] por_cnt_d;
	logic ctl_wr;
	logic ctl;
	assign ctl = sfr_addr == wdt_pkg::watchdog_control_addr;
	assign ctl_wr = sfr_wr && !system_reset && ctl;
	always_comb por_cnt_d = system_reset ? por_cnt_q + 32'h1 : por_cnt_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			por_cnt_q <= 32'h0;
		else
			por_cnt_q <= por_cnt_d;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_PULSE_ONE: assert property (watchdog_reset_pulse |=> !watchdog_reset_pulse)
		else $error("reset pulse longer than one cycle");
	AST_NO_PULSE_IN_POR: assert property (system_reset |-> !watchdog_reset_pulse)
		else $error("watchdog pulse during power-on reset");
	AST_POR_HOLD: assert property (
		(system_reset && por_cnt_q < 32'(por_release_clocks - 2)) |=> system_reset)
		else $error("power-on reset released early");
	AST_UNMAPPED: assert property ((!ctl && sfr_addr != wdt_pkg::power_control_addr)
		|=> sfr_rdata == 8'h00)
		else $error("unmapped address reads nonzero");
	AST_POWER_BITS: assert property (sfr_addr == wdt_pkg::power_control_addr
		|=> (sfr_rdata & 8'hef) == 8'h00)
		else $error("power register spare bits nonzero");
	AST_POWER_FLAG: assert property ($fell(system_reset) && !sfr_wr ##1
		sfr_addr == wdt_pkg::power_control_addr |=> sfr_rdata[wdt_pkg::power_on_flag_pos])
		else $error("power-on flag not set after power-on");
	AST_FLAG_KEPT: assert property (watchdog_reset_pulse ##1 ctl
		|=> sfr_rdata[wdt_pkg::flag_pos])
		else $error("watchdog flag lost after overflow");
	AST_RESTART_CLEAR: assert property (ctl_wr && sfr_wdata[wdt_pkg::restart_pos]
		##1 (ctl && !sfr_wr)[*2] |=> !sfr_rdata[wdt_pkg::restart_pos])
		else $error("restart bit did not self-clear");
	AST_CTRL_BACK: assert property (ctl_wr ##1 (ctl && !sfr_wr)
		|=> (sfr_rdata & 8'h2f) == ($past(sfr_wdata, 2) & 8'h2f))
		else $error("control readback differs");
endmodule : wdt_top_monitor
bind wdt_top wdt_top_monitor #(.power_up_delay_clocks(power_up_delay_clocks),
	.por_release_clocks(por_release_clocks)) mon_u (.ref_clk(ref_clk), .rst(rst),
	.power_up_delay_en(power_up_delay_en), .cpu_idle(cpu_idle), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
	.system_reset(system_reset), .watchdog_reset_pulse(watchdog_reset_pulse));

// ==== sim/testbench.sv ====
// testbench: register accesses, power-on release and flags of the watchdog
// assumes wdt_top with shortened power-on counts
`timescale 1ns/1ps
module testbench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic power_up_delay_en = 1'b0;
	logic cpu_idle = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic system_reset;
	logic watchdog_reset_pulse;
	int error_cnt = 0;
	int n_compared = 0;
	int pulse_cnt = 0;
	// short watchdog counter so that overflows fit the run
	localparam int wd_width = 4;
	localparam int ovf_ps0 = wdt_pkg::base_divide * 2 * (1 << wd_width);
	localparam int ovf_ps1 = wdt_pkg::base_divide * 4 * (1 << wd_width);
	wdt_top #(.power_up_delay_clocks(100), .por_release_clocks(16),
		.counter_width(wd_width)) dut_u (
		.ref_clk(ref_clk), .rst(rst), .power_up_delay_en(power_up_delay_en),
		.cpu_idle(cpu_idle), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .system_reset(system_reset),
		.watchdog_reset_pulse(watchdog_reset_pulse));
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	// count reset pulses where they are settled
	always @(negedge ref_clk) begin
		if (watchdog_reset_pulse === 1'b1) begin
			pulse_cnt <= pulse_cnt + 1;
		end
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		sfr_addr <= addr;
		sfr_wdata <= data;
		sfr_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : reg_write
	task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
		sfr_addr <= addr;
		@(posedge ref_clk);
		#1 check(sfr_rdata, exp);
		@(posedge ref_clk);
	endtask : reg_read
	task automatic wait_por(input int lo);
		int n;
		n = 0;
		while (system_reset === 1'b1 && n < 1000) begin
			@(posedge ref_clk);
			#1 n++;
		end
		check(8'(n >= lo && n <= lo + 2), 8'h01);
		@(posedge ref_clk);
	endtask : wait_por
	task automatic wait_pulse(input int lo);
		int n;
		n = 0;
		while (watchdog_reset_pulse !== 1'b1 && n < 2000) begin
			@(posedge ref_clk);
			#1 n++;
		end
		check(8'(n >= lo && n <= lo + 3), 8'h01);
		@(posedge ref_clk);
	endtask : wait_pulse
	task automatic expect_quiet(input int cycles);
		int start;
		start = pulse_cnt;
		repeat (cycles) @(posedge ref_clk);
		check(8'(pulse_cnt - start), 8'h00);
	endtask : expect_quiet
	task automatic test_done();
		$display("compared %0d, wrong %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		wait_por(16);
		reg_read(8'h87, 8'h10);
		reg_read(8'hc1, 8'h00);
		$display("test power-on release done");
		for (int i = 0; i < 16; i++) begin
			cpu_idle <= i[0];
			reg_write(8'hc1, 8'h20 | 8'(i));
			reg_read(8'hc1, 8'h20 | 8'(i));
		end
		$display("test control fields done");
		reg_write(8'hc1, 8'hbf);
		reg_read(8'h55, 8'h00);
		reg_read(8'hc1, 8'h2f);
		reg_write(8'hc1, 8'h00);
		reg_read(8'hc1, 8'h00);
		reg_write(8'h87, 8'hff);
		reg_read(8'h87, 8'h10);
		reg_write(8'h87, 8'h00);
		reg_read(8'h87, 8'h00);
		reg_write(8'h55, 8'hff);
		reg_read(8'h55, 8'h00);
		$display("test restart and flags done");
		cpu_idle <= 1'b0;
		reg_write(8'hc1, 8'h30);
		wait_pulse(ovf_ps0);
		reg_read(8'hc1, 8'h80);
		reg_write(8'hc1, 8'h00);
		reg_read(8'hc1, 8'h00);
		reg_write(8'hc1, 8'h31);
		wait_pulse(ovf_ps1);
		reg_write(8'hc1, 8'h30);
		reg_write(8'hc1, 8'h10);
		expect_quiet(2 * ovf_ps0);
		reg_write(8'hc1, 8'h30);
		for (int i = 0; i < 4; i++) begin
			expect_quiet(ovf_ps0 - 100);
			reg_write(8'hc1, 8'h30);
		end
		reg_write(8'hc1, 8'h00);
		$display("test overflow and restart done");
		cpu_idle <= 1'b1;
		reg_write(8'hc1, 8'h30);
		expect_quiet(2 * ovf_ps0);
		cpu_idle <= 1'b0;
		wait_pulse(ovf_ps0);
		cpu_idle <= 1'b1;
		reg_write(8'hc1, 8'h38);
		wait_pulse(ovf_ps0);
		reg_read(8'hc1, 8'h80);
		cpu_idle <= 1'b0;
		reg_write(8'hc1, 8'h00);
		$display("test idle mode done");
		rst <= 1'b1;
		@(posedge ref_clk);
		rst <= 1'b0;
		power_up_delay_en <= 1'b1;
		reg_write(8'hc1, 8'h27);
		wait_por(114);
		reg_read(8'hc1, 8'h00);
		reg_read(8'h87, 8'h10);
		$display("test delayed power-up done");
		test_done();
	end
	initial begin
		repeat (12000) @(posedge ref_clk);
		error_cnt++;
		test_done();
	end
endmodule : testbench
